/* rtl/ftw_fifo_threshold_wake.v */
// FIFO threshold configuration register, threshold flags and wake-time analog test presets
// Assumes the serial register front end and FIFO counters run on CORE_CLK
// The readable test registers live elsewhere; wake presets reach only the analog outputs
`timescale 1ns/1ps
`include "ftw_map.vh"

// Behaviour
// [RULE1] Software writes zero to reserved top bit
// [RULE2] Retention clear: load first preset pair on wake
// [RULE3] Retention set: load alternative preset pair on wake
// [RULE4] Wake presets reach analog only, reads unchanged
// [RULE5] Flag set when FIFO count reaches threshold
// [RULE6] TX 61 minus 4n, RX 4(n+1)
// [RULE7] Compare both counts every clock cycle
module ftw_fifo_threshold_wake (
	// Clock and reset
	input  wire       CORE_CLK,
	input  wire       RESETN,
	// Register port from the serial front end
	input  wire [5:0] REG_ADDR,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	output reg        REG_RVALID,
	// FIFO fill levels
	input  wire [6:0] TX_FIFO_COUNT,
	input  wire [6:0] RX_FIFO_COUNT,
	output reg        TX_THR_REACHED,
	output reg        RX_THR_REACHED,
	// Sleep wake-up and analog test settings
	input  wire       WAKE_FROM_SLEEP,
	output reg  [7:0] ANALOG_TEST_SETTING_ONE,
	output reg  [7:0] ANALOG_TEST_SETTING_TWO,
	output reg        ANALOG_TEST_LOAD,
	// Rx attenuation field for the analog section
	output reg  [1:0] RX_ATTEN_SELECT
);

	// Stored configuration
	reg  [7:0] fifo_level_and_wake_setup_r;
	reg  [7:0] fifo_level_and_wake_setup_nxt;
	// Next values of the registered outputs
	reg  [7:0] reg_rdata_nxt;
	reg        reg_rvalid_nxt;
	reg        tx_thr_reached_nxt;
	reg        rx_thr_reached_nxt;
	reg  [7:0] analog_test_setting_one_nxt;
	reg  [7:0] analog_test_setting_two_nxt;
	reg        analog_test_load_nxt;
	reg  [1:0] rx_atten_select_nxt;
	// Decoded strobes, fields and comparisons
	wire       reg_hit;
	wire       reg_write;
	wire       reg_read;
	wire [3:0] fifo_level_select;
	wire       converter_setting_keep;
	wire [1:0] rx_atten_field;
	wire [6:0] tx_thr;
	wire [6:0] rx_thr;
	wire       tx_level_met;
	wire       rx_level_met;

	// Threshold for a level setting; tx selects the transmit table
	function [6:0] thr_of;
		input [3:0] lvl;
		input       tx;
		reg   [6:0] step_sum;
		begin
			step_sum = {1'h0, lvl, 2'h0};
			if (tx) begin
				thr_of = `FTW_TX_THR_BASE - step_sum; // RULE6
			end else begin
				thr_of = step_sum + `FTW_THR_STEP; // RULE6
			end
		end
	endfunction

	// Reaching the threshold already counts as exceeded
	function level_met;
		input [6:0] count;
		input [6:0] thr;
		begin
			level_met = (count >= thr); // RULE5
		end
	endfunction

	// Wake preset for one analog test setting; second picks setting two
	function [7:0] wake_preset;
		input keep;
		input second;
		begin
			if (keep && second) begin
				wake_preset = `FTW_T2_KEEP_SET; // RULE3
			end else if (keep) begin
				wake_preset = `FTW_T1_KEEP_SET; // RULE3
			end else if (second) begin
				wake_preset = `FTW_T2_KEEP_CLR; // RULE2
			end else begin
				wake_preset = `FTW_T1_KEEP_CLR; // RULE2
			end
		end
	endfunction

	// Field decode and threshold comparisons
	assign reg_hit                = (REG_ADDR == `FTW_LEVEL_WAKE_ADDR);
	assign reg_write              = REG_WR && reg_hit;
	assign reg_read               = REG_RD;
	assign fifo_level_select      = fifo_level_and_wake_setup_r[`FTW_LEVEL_HI:`FTW_LEVEL_LO];
	assign converter_setting_keep = fifo_level_and_wake_setup_r[`FTW_KEEP_BIT];
	assign rx_atten_field         = fifo_level_and_wake_setup_r[`FTW_ATTEN_HI:`FTW_ATTEN_LO];
	assign tx_thr                 = thr_of(fifo_level_select, 1'h1);
	assign rx_thr                 = thr_of(fifo_level_select, 1'h0);
	assign tx_level_met           = level_met(TX_FIFO_COUNT, tx_thr); // RULE7
	assign rx_level_met           = level_met(RX_FIFO_COUNT, rx_thr); // RULE7

	// Reserved bit is stored as written; software keeps it at zero
	always @* begin
		fifo_level_and_wake_setup_nxt = fifo_level_and_wake_setup_r;
		if (reg_write) begin
			fifo_level_and_wake_setup_nxt = REG_WDATA;
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			fifo_level_and_wake_setup_r <= `FTW_LEVEL_WAKE_RESET;
		end else begin
			fifo_level_and_wake_setup_r <= fifo_level_and_wake_setup_nxt;
		end
	end

	// Read answer one cycle after the strobe; data holds until the next read
	always @* begin
		reg_rvalid_nxt = reg_read;
		reg_rdata_nxt  = REG_RDATA;
		if (reg_read && reg_hit) begin
			reg_rdata_nxt = fifo_level_and_wake_setup_r;
		end else if (reg_read) begin
			reg_rdata_nxt = `FTW_UNMAPPED_DATA;
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			REG_RDATA <= `FTW_RDATA_RESET;
		end else begin
			REG_RDATA <= reg_rdata_nxt;
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			REG_RVALID <= `FTW_FLAG_RESET;
		end else begin
			REG_RVALID <= reg_rvalid_nxt;
		end
	end

	// Flags follow the fill levels every cycle
	always @* begin
		tx_thr_reached_nxt = tx_level_met; // RULE5
		rx_thr_reached_nxt = rx_level_met; // RULE5
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			TX_THR_REACHED <= `FTW_FLAG_RESET;
		end else begin
			TX_THR_REACHED <= tx_thr_reached_nxt; // RULE7
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			RX_THR_REACHED <= `FTW_FLAG_RESET;
		end else begin
			RX_THR_REACHED <= rx_thr_reached_nxt; // RULE7
		end
	end

	// Wake presets drive only the analog outputs, never the register readback
	always @* begin
		analog_test_load_nxt        = WAKE_FROM_SLEEP; // RULE4
		analog_test_setting_one_nxt = ANALOG_TEST_SETTING_ONE;
		analog_test_setting_two_nxt = ANALOG_TEST_SETTING_TWO;
		if (WAKE_FROM_SLEEP) begin
			analog_test_setting_one_nxt = wake_preset(converter_setting_keep, 1'h0);
			analog_test_setting_two_nxt = wake_preset(converter_setting_keep, 1'h1);
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ANALOG_TEST_SETTING_ONE <= `FTW_T1_KEEP_CLR;
			ANALOG_TEST_SETTING_TWO <= `FTW_T2_KEEP_CLR;
		end else begin
			ANALOG_TEST_SETTING_ONE <= analog_test_setting_one_nxt; // RULE2 RULE3
			ANALOG_TEST_SETTING_TWO <= analog_test_setting_two_nxt; // RULE2 RULE3
		end
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			ANALOG_TEST_LOAD <= `FTW_FLAG_RESET;
		end else begin
			ANALOG_TEST_LOAD <= analog_test_load_nxt;
		end
	end

	// Attenuation field only feeds the analog section
	always @* begin
		rx_atten_select_nxt = rx_atten_field;
	end

	always @(posedge CORE_CLK) begin
		if (!RESETN) begin
			RX_ATTEN_SELECT <= `FTW_ATTEN_RESET;
		end else begin
			RX_ATTEN_SELECT <= rx_atten_select_nxt;
		end
	end

endmodule // ftw_fifo_threshold_wake

/* include/ftw_map.vh */
// Register map, field positions, reset values and presets for the FIFO threshold / wake block
// Assumes inclusion by bare name from the design files
`ifndef FTW_MAP_VH
`define FTW_MAP_VH

// Register offset on the serial register port
`define FTW_ADDR_W            6
`define FTW_LEVEL_WAKE_ADDR   6'h03

// Field positions
`define FTW_RSVD_BIT          7
`define FTW_KEEP_BIT          6
`define FTW_ATTEN_HI          5
`define FTW_ATTEN_LO          4
`define FTW_LEVEL_HI          3
`define FTW_LEVEL_LO          0

// Reset value: level select 7, everything else 0
`define FTW_LEVEL_WAKE_RESET  8'h07

// Reset values of the registered outputs
`define FTW_RDATA_RESET       8'h00
`define FTW_FLAG_RESET        1'h0
`define FTW_ATTEN_RESET       2'h0

// Threshold arithmetic
`define FTW_TX_THR_BASE       7'h3D
`define FTW_THR_STEP          7'h04

// Wake presets for the two internal analog test settings
`define FTW_T1_KEEP_CLR       8'h31
`define FTW_T2_KEEP_CLR       8'h88
`define FTW_T1_KEEP_SET       8'h35
`define FTW_T2_KEEP_SET       8'h81

// Read answer for an unmapped offset
`define FTW_UNMAPPED_DATA     8'h00

`endif

/* tb/ftw_properties.sv */
// Checker for threshold flags, wake presets and readback
// Bound to the block; sees its ports only
`timescale 1ns/1ps
module ftw_props (
	// Clock and reset
	input wire       CORE_CLK,
	input wire       RESETN,
	// Register port
	input wire [5:0] REG_ADDR,
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire       REG_RVALID,
	// FIFO fill levels and flags
	input wire [6:0] TX_FIFO_COUNT,
	input wire [6:0] RX_FIFO_COUNT,
	input wire       TX_THR_REACHED,
	input wire       RX_THR_REACHED,
	// Wake and analog outputs
	input wire       WAKE_FROM_SLEEP,
	input wire [7:0] ANALOG_TEST_SETTING_ONE,
	input wire [7:0] ANALOG_TEST_SETTING_TWO,
	input wire       ANALOG_TEST_LOAD,
	input wire [1:0] RX_ATTEN_SELECT
);
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RESETN);
reg  [7:0]  sh_r;
wire [6:0]  tx_thr = 7'h3D - {1'b0, sh_r[3:0], 2'b00};
wire [6:0]  rx_thr = {1'b0, sh_r[3:0], 2'b00} + 7'h04;
wire [15:0] set_w  = {ANALOG_TEST_SETTING_ONE, ANALOG_TEST_SETTING_TWO};
// Shadow of the configuration register
always @(posedge CORE_CLK)
	if (!RESETN) sh_r <= 8'h07;
	else if (REG_WR && REG_ADDR == 6'h03) sh_r <= REG_WDATA;
sequence s_wake(k); WAKE_FROM_SLEEP && sh_r[6] == k; endsequence
a_tx_flag_level: assert property (TX_THR_REACHED == ($past(TX_FIFO_COUNT) >= $past(tx_thr)))
	else $error("tx flag wrong");
a_rx_flag_level: assert property (RX_THR_REACHED == ($past(RX_FIFO_COUNT) >= $past(rx_thr)))
	else $error("rx flag wrong");
a_wake_clear: assert property (s_wake(0) |=> ANALOG_TEST_LOAD && set_w == 16'h3188)
	else $error("wake preset wrong");
a_wake_keep: assert property (s_wake(1) |=> ANALOG_TEST_LOAD && set_w == 16'h3581)
	else $error("keep preset wrong");
a_load_cause: assert property (ANALOG_TEST_LOAD |-> $past(WAKE_FROM_SLEEP))
	else $error("load without wake");
a_read_back: assert property (REG_RD && REG_ADDR == 6'h03 |=> REG_RVALID && REG_RDATA == $past(sh_r))
	else $error("readback wrong");
a_atten_copy: assert property (RX_ATTEN_SELECT == $past(sh_r[5:4]))
	else $error("attenuation copy wrong");
a_rvalid_once: assert property (REG_RVALID == $past(REG_RD))
	else $error("read valid timing wrong");
endmodule // ftw_props
bind ftw_fifo_threshold_wake ftw_props u_ftw_props(.*);

/* tb/ftw_host.sv */
// Host side of the register port
// Strobes one cycle wide, released lines inverted
`timescale 1ns/1ps
module ftw_host (
	// Clock
	input  wire       clk,
	// Register port toward the block
	output reg  [5:0] a,
	output reg        wr,
	output reg        rd,
	output reg  [7:0] d
);
initial {a, wr, rd, d} = 0;
task xfer(input w, input [5:0] ad, input [7:0] dt);
	begin
		@(posedge clk);
		#1 a = ad;
		d = dt & 8'h7F;
		wr = w;
		rd = !w;
		@(posedge clk);
		#1 {wr, rd} = 0;
		a = ~ad;
		d = ~d;
	end
endtask
endmodule // ftw_host

/* tb/test_fifo_threshold_wake_config.sv */
// Testbench: register access, random fill levels, wake-ups
// Flags and presets are judged by the bound checker
`timescale 1ns/1ps
module test_fifo_threshold_wake_config;
reg clk = 0, rstn = 0, wake = 0;
reg [6:0] txc = 0, rxc = 0;
reg [7:0] v, e = 8'h07;
reg [11:0] rn, exq[$];
reg [17:0] wn, wkq[$];
wire [5:0] a;
wire wr, rd, rv, tf, rf, ld;
wire [7:0] wd, q, s1, s2;
wire [1:0] at;
integer seed = 32'hd337, error_cnt = 0, n_tests = 0, i;
initial forever #12.5 clk = ~clk;
ftw_host u_ftw_host(.clk(clk), .a(a), .wr(wr), .rd(rd), .d(wd));
ftw_fifo_threshold_wake u_ftw_fifo_threshold_wake(.CORE_CLK(clk), .RESETN(rstn), .REG_ADDR(a),
	.REG_WR(wr), .REG_RD(rd), .REG_WDATA(wd), .REG_RDATA(q), .REG_RVALID(rv),
	.TX_FIFO_COUNT(txc), .RX_FIFO_COUNT(rxc), .TX_THR_REACHED(tf), .RX_THR_REACHED(rf),
	.WAKE_FROM_SLEEP(wake), .ANALOG_TEST_SETTING_ONE(s1), .ANALOG_TEST_SETTING_TWO(s2),
	.ANALOG_TEST_LOAD(ld), .RX_ATTEN_SELECT(at));
task results;
	if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
task rd_chk(input [5:0] ad, input [7:0] ex);
	begin
		exq.push_back({e[5:4], 2'h0, ex});
		u_ftw_host.xfer(0, ad, 8'h00);
		@(posedge clk);
	end
endtask
// Read answers, with attenuation and flags, against the oldest expectation
always @(negedge clk) if (rv === 1'b1) begin
	n_tests = n_tests + 1;
	rn = exq.pop_front();
	if ({at, tf, rf, q} !== rn) begin
		error_cnt = error_cnt + 1;
		$display("[FAIL] atten flags rdata exp %h got %h", rn, {at, tf, rf, q});
	end
end
// Wake loads: flags at threshold and the preset pair
always @(negedge clk) if (ld === 1'b1) begin
	n_tests = n_tests + 1;
	wn = wkq.pop_front();
	if ({tf, rf, s1, s2} !== wn) begin
		error_cnt = error_cnt + 1;
		$display("[FAIL] wake flags settings exp %h got %h", wn, {tf, rf, s1, s2});
	end
end
initial begin
	#100000 error_cnt = error_cnt + 1;
	results;
end
initial begin
	repeat (3) @(posedge clk);
	#1 rstn = 1;
	rd_chk(6'h03, 8'h07);
	rd_chk(6'h05, 8'h00);
	for (i = 0; i < 32; i = i + 1) begin
		v = $random(seed);
		v[3:0] = i[3:0];
		u_ftw_host.xfer(1, (i == 9) ? 6'h04 : 6'h03, v);
		if (i != 9) e = v & 8'h7F;
		repeat (4) begin
			@(posedge clk);
			#1 txc = $unsigned($random(seed)) % 65;
			rxc = $unsigned($random(seed)) % 65;
		end
		@(posedge clk);
		#1 txc = 7'h3D - {1'b0, e[3:0], 2'b00};
		rxc = {1'b0, e[3:0], 2'b00} + 7'h04;
		wake = 1;
		wkq.push_back({2'h3, e[6] ? 16'h3581 : 16'h3188});
		@(posedge clk);
		#1 wake = 0;
		txc = txc - 7'h01;
		rxc = rxc - 7'h01;
		rd_chk(6'h03, e);
	end
	results;
end
endmodule // test_fifo_threshold_wake_config
